// ### cts_pkg.sv
// Constants and types for the control law coprocessor task sequencer
// Operation
// - Eight independent task slots, each naming its own routine.
// - Each slot starts from a software write or a peripheral trigger.
// - One task runs at a time and always finishes before another starts.
// - Task completion raises an interrupt toward the peripheral interrupt expander.
// - After completion the highest-priority pending task starts without CPU help.
// - Coprocessor has its own bus path to converter and peripheral registers.
// - CPU and coprocessor exchange data through shared message memories.
// - Independent engine with own fetch and pipeline, 32-bit floating point.
package cts_pkg;
    localparam int NUM_TASKS = 8;
    localparam int TASK_IDX_W = 3;
    localparam logic [NUM_TASKS-1:0] PEND_RESET = 8'h00;
    localparam logic [TASK_IDX_W-1:0] IDX_RESET = 3'h0;

    // Sequencer states, one-hot
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_LAUNCH = 3'b010,
        ST_RUN = 3'b100
    } cts_state_type;

    // Launch command toward the execution engine
    typedef struct packed
    {
        logic valid;
        logic [TASK_IDX_W-1:0] task_idx;
    } cts_launch_type;

    // Completion report toward the interrupt expander
    typedef struct packed
    {
        logic pulse;
        logic [TASK_IDX_W-1:0] task_idx;
    } cts_done_type;
endpackage : cts_pkg

// ### cts_task_sequencer.sv
// Task sequencer: pending slots, priority pick, launch and completion
`timescale 1ns/10ps
`default_nettype none
module cts_task_sequencer
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // Start requests, one bit per slot
    input wire logic [cts_pkg::NUM_TASKS-1:0] SW_START_I,
    input wire logic [cts_pkg::NUM_TASKS-1:0] PERIPH_TRIG_I,
    // Execution engine handshake
    output cts_pkg::cts_launch_type LAUNCH_O,
    input wire logic ENGINE_DONE_I,
    // Completion interrupt toward the interrupt expander
    output cts_pkg::cts_done_type DONE_O,
    // Status
    output logic BUSY_O,
    output logic [cts_pkg::NUM_TASKS-1:0] PENDING_O
);
    import cts_pkg::*;

    cts_state_type state;
    cts_state_type next_state;
    logic [NUM_TASKS-1:0] pend;
    logic [NUM_TASKS-1:0] trig_s1;
    logic [NUM_TASKS-1:0] trig_s2;
    logic [NUM_TASKS-1:0] trig_d;
    logic [NUM_TASKS-1:0] trig_rise;
    logic [TASK_IDX_W-1:0] cur_idx;
    logic [TASK_IDX_W-1:0] pick_idx;
    logic start_now;
    logic done_ev;
    logic [NUM_TASKS-1:0] next_pend;
    logic launch_valid;
    logic [TASK_IDX_W-1:0] launch_idx;
    logic done_pulse;
    logic [TASK_IDX_W-1:0] done_idx;

    // Lowest-numbered pending slot has priority
    function automatic logic [TASK_IDX_W-1:0] pick_lowest(input logic [NUM_TASKS-1:0] p);
        logic [TASK_IDX_W-1:0] r;
        r = IDX_RESET;
        for (int i = NUM_TASKS - 1; i >= 0; i--)
        begin
            if (p[i])
            begin
                r = TASK_IDX_W'(i);
            end
        end
        return r;
    endfunction : pick_lowest

    // One-hot mask of a slot number
    function automatic logic [NUM_TASKS-1:0] slot_mask(input logic [TASK_IDX_W-1:0] idx);
        return NUM_TASKS'(1) << idx;
    endfunction : slot_mask

    // Peripheral triggers come from other logic timing; sync then edge detect
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            trig_s1 <= PEND_RESET;
            trig_s2 <= PEND_RESET;
        end
        else
        begin
            trig_s1 <= PERIPH_TRIG_I;
            trig_s2 <= trig_s1;
        end
    end

    // Edge history resets low like an idle pin, so no false edge after reset
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            trig_d <= PEND_RESET;
        end
        else
        begin
            trig_d <= trig_s2;
        end
    end

    assign trig_rise = trig_s2 & ~trig_d;
    assign pick_idx = pick_lowest(pend);
    assign done_ev = (state == ST_RUN) && ENGINE_DONE_I;
    // Start only from idle or straight after a finish; never preempts
    assign start_now = (pend != PEND_RESET) && ((state == ST_IDLE) || done_ev);

    // Launch clears its slot first, then new requests merge on top;
    // a request arriving in the launch cycle is therefore never lost
    always_comb
    begin
        next_pend = pend;
        if (start_now)
        begin
            next_pend = next_pend & ~slot_mask(pick_idx);
        end
        next_pend = next_pend | SW_START_I | trig_rise;
    end

    // Pending set, one bit per slot
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            pend <= PEND_RESET;
        end
        else
        begin
            pend <= next_pend;
        end
    end

    // Sequencer state
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (start_now)
                begin
                    next_state = ST_LAUNCH;
                end
            end
            ST_LAUNCH:
            begin
                next_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (done_ev)
                begin
                    next_state = start_now ? ST_LAUNCH : ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Current task index, captured at selection time
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            cur_idx <= IDX_RESET;
        end
        else if (start_now)
        begin
            cur_idx <= pick_idx;
        end
    end

    // Launch strobe for one cycle; engine owns fetch and arithmetic
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            launch_valid <= 1'b0;
        end
        else
        begin
            launch_valid <= start_now;
        end
    end

    // Slot number picks the routine; bus path and message memories sit in the engine
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            launch_idx <= IDX_RESET;
        end
        else if (start_now)
        begin
            launch_idx <= pick_idx;
        end
    end

    // Completion pulse, one cycle per finished task
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            done_pulse <= 1'b0;
        end
        else
        begin
            done_pulse <= done_ev;
        end
    end

    // Finished slot number holds until the next completion
    always_ff @(posedge CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            done_idx <= IDX_RESET;
        end
        else if (done_ev)
        begin
            done_idx <= cur_idx;
        end
    end

    // Registered fields packed onto the port structs
    assign LAUNCH_O = '{valid: launch_valid, task_idx: launch_idx};
    assign DONE_O = '{pulse: done_pulse, task_idx: done_idx};

    assign BUSY_O = (state != ST_IDLE);
    assign PENDING_O = pend;
endmodule : cts_task_sequencer
`default_nettype wire

// ### cts_checker.sv
// Port assertions for the task sequencer
`timescale 1ns/10ps
`default_nettype none
module cts_checker
(
    // Watched ports
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire cts_pkg::cts_launch_type LAUNCH_O,
    input wire logic ENGINE_DONE_I,
    input wire cts_pkg::cts_done_type DONE_O,
    input wire logic BUSY_O,
    input wire logic [7:0] PENDING_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Done while a task really runs
    sequence s_run;
        ENGINE_DONE_I && BUSY_O && !LAUNCH_O.valid;
    endsequence
    a_done_irq: assert property (s_run |=> DONE_O.pulse) else $error("lost done");
    a_done_slot: assert property (s_run |=> DONE_O.task_idx == $past(LAUNCH_O.task_idx))
        else $error("bad done slot");
    a_done_refused: assert property (ENGINE_DONE_I && (!BUSY_O || LAUNCH_O.valid)
        |=> !DONE_O.pulse) else $error("stray done");
    a_idle_start: assert property (!BUSY_O && PENDING_O != 8'h00 |=> LAUNCH_O.valid)
        else $error("no start");
    a_next_start: assert property (s_run ##0 PENDING_O != 8'h00 |=> LAUNCH_O.valid)
        else $error("no next");
    a_one_task: assert property (LAUNCH_O.valid |-> DONE_O.pulse || !$past(BUSY_O))
        else $error("preempted");
    a_low_first: assert property (LAUNCH_O.valid |->
        ($past(PENDING_O) & -$past(PENDING_O)) == 8'h01 << LAUNCH_O.task_idx) else $error("order");
    a_pulse_once: assert property (DONE_O.pulse |=> !DONE_O.pulse) else $error("long");
endmodule : cts_checker
bind cts_task_sequencer cts_checker u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .LAUNCH_O(LAUNCH_O),
    .ENGINE_DONE_I(ENGINE_DONE_I), .DONE_O(DONE_O), .BUSY_O(BUSY_O), .PENDING_O(PENDING_O));
`default_nettype wire

// ### cts_engine_model.sv
// Engine model: done a set latency after each launch
`timescale 1ns/10ps
`default_nettype none
module cts_engine_model
(
    // Clock, reset, launch, latency, done
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire cts_pkg::cts_launch_type launch_i,
    input wire logic [3:0] lat_i,
    output logic done_o
);
    logic [3:0] cnt;
    // Off the falling edge, so done never races the launch edge
    always_ff @(negedge clk_i or negedge rstn_i)
        if (!rstn_i)
            cnt <= 4'h0;
        else
            cnt <= launch_i.valid ? lat_i : cnt - 4'(cnt != 4'h0);
    assign done_o = cnt == 4'h1;
endmodule : cts_engine_model
`default_nettype wire

// ### accelerator_task_sequencer_tb.sv
// Random and corner stimulus for the task sequencer
`timescale 1ns/10ps
`default_nettype none
module accelerator_task_sequencer_tb;
    import cts_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, stray = 1'b0, eng;
    logic [7:0] sw = 8'h00, trig = 8'h00, pend, ep, inj;
    logic [3:0] lat = 4'h4;
    logic [2:0] e;
    logic busy;
    cts_launch_type launch;
    cts_done_type done;
    int bad_count = 0, tests_run = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    cts_task_sequencer u_dut (.CLK_I(clk), .RSTN_I(rstn), .SW_START_I(sw), .PERIPH_TRIG_I(trig),
        .LAUNCH_O(launch), .ENGINE_DONE_I(eng | stray), .DONE_O(done), .BUSY_O(busy),
        .PENDING_O(pend));
    cts_engine_model u_eng (.clk_i(clk), .rstn_i(rstn), .launch_i(launch), .lat_i(lat),
        .done_o(eng));
    task automatic print_verdict();
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        tests_run++;
        if (got !== want)
        begin
            bad_count++;
            $display("unexpected %0t %h %h", $time, got, want);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic want);
        tests_run++;
        if (got !== want)
        begin
            bad_count++;
            $display("unexpected %0t %h %h", $time, got, want);
        end
    endtask : chk_bit
    // Expected winner: lowest-numbered pending slot
    function automatic logic [2:0] lowest_slot(input logic [7:0] p);
        logic [2:0] w;
        w = 3'h0;
        for (int i = 7; i >= 0; i--)
            if (p[i])
                w = 3'(i);
        return w;
    endfunction : lowest_slot
    // Bounded wait for a launch (0) or a done pulse (1)
    task automatic wt(input logic sel);
        for (int n = 0; n < 40; n++)
        begin
            if ((sel ? done.pulse : launch.valid) === 1'b1)
                return;
            @(negedge clk);
        end
        bad_count++;
        print_verdict();
    endtask : wt
    // Rounds: idle stray done, burst request, re-request mid-run
    initial
    begin
        void'($urandom(75803));
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        for (int r = 0; r < 16; r++)
        begin
            stray = 1'b1;
            @(negedge clk);
            stray = 1'b0;
            lat = 4'h4 + 4'($urandom_range(4));
            ep = r == 0 ? 8'h04 : r == 1 ? 8'hFF : 8'($urandom_range(255, 1));
            inj = 8'($urandom);
            sw = ep;
            @(negedge clk);
            sw = 8'h00;
            while (ep != 8'h00)
            begin
                wt(1'b0);
                e = lowest_slot(ep);
                chk({5'h0, launch.task_idx}, {5'h0, e});
                chk_bit(busy, 1'b1);
                ep[e] = 1'b0;
                chk(pend, ep);
                ep |= inj;
                if (r[0])
                    trig = inj;
                else
                    sw = inj;
                inj = 8'h00;
                // Done in the launch cycle must be ignored
                stray = r[1];
                @(negedge clk);
                sw = 8'h00;
                stray = 1'b0;
                wt(1'b1);
                chk({5'h0, done.task_idx}, {5'h0, e});
            end
            chk(pend, 8'h00);
            chk_bit(busy, 1'b0);
            trig = 8'h00;
        end
        print_verdict();
    end
endmodule : accelerator_task_sequencer_tb
`default_nettype wire
